// File: design/pm_cfg_pkg.sv
/*
 * Constants for the configuration header upper words: offsets, fields,
 * fixed values and reset values.
 * Assumes a 32-bit configuration data path with byte enables.
 */
package pm_cfg_pkg;
    localparam logic [15:0] OFS_SUBSYS_ID = 16'h202C;
    localparam logic [15:0] OFS_CAP_PTR = 16'h2034;
    localparam logic [15:0] OFS_INT_LAT = 16'h203C;
    localparam logic [15:0] OFS_PM_CAP = 16'h2050;
    localparam logic [15:0] OFS_PM_CSR = 16'h2054;
    localparam logic [7:0] CAP_PTR_VAL = 8'h50;
    localparam logic [7:0] MAX_LAT_RST = 8'h28;
    localparam logic [7:0] MIN_GNT_RST = 8'h14;
    localparam logic [7:0] INT_PIN_VAL = 8'h01;
    localparam logic [7:0] INT_LINE_RST = 8'h00;
    localparam logic [7:0] PM_CAP_ID_VAL = 8'h01;
    localparam logic [7:0] PM_NEXT_VAL = 8'h00;
    localparam logic [2:0] PM_VER_VAL = 3'h3;
    localparam logic [2:0] AUX_CUR_VAL = 3'h0;
    localparam logic [31:0] SUBSYS_RST = 32'h0000_0000;
    localparam int WAKE_STATUS_BIT = 15;
    localparam int WAKE_ENABLE_BIT = 8;
    localparam int NO_SOFT_RST_BIT = 3;
    localparam logic [1:0] PSTATE_RST = 2'h0;
    typedef enum logic [1:0] {
        PS_D0, PS_D1, PS_D2, PS_D3HOT
    } pstate_t;
endpackage : pm_cfg_pkg

// File: design/sync_two_ff.sv
/*
 * Two flip-flop synchroniser for one level.
 * Assumes the input is asynchronous to core_clk_in.
 */
`timescale 1ns/10ps
`default_nettype none
module sync_two_ff (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic d_in,
    output logic q_out
);
    logic meta_r;
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_r <= 1'b0;
            q_out <= 1'b0;
        end else begin
            meta_r <= d_in;
            q_out <= meta_r;
        end
    end
endmodule : sync_two_ff
`default_nettype wire

// File: design/pci_cfg_pm_capability_regs.sv
/*
 * Upper configuration header words and power-management capability.
 * Assumes a single-cycle configuration port on the PCI clock domain and
 * a local-processor write port on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
module pci_cfg_pm_capability_regs
    import pm_cfg_pkg::*;
(
    // Clock and resets
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic pwr_on_rst_in,
    // Configuration port
    input wire logic cfg_req_in,
    input wire logic cfg_wr_in,
    input wire logic [15:0] cfg_addr_in,
    input wire logic [3:0] cfg_be_in,
    input wire logic [31:0] cfg_wdata_in,
    output logic cfg_ack_out,
    output logic cfg_retry_out,
    output logic cfg_hit_out,
    output logic [31:0] cfg_rdata_out,
    // Local processor port
    input wire logic local_sid_wr_in,
    input wire logic [31:0] local_sid_data_in,
    // Wake event and power state
    input wire logic wake_event_in,
    output logic wake_event_out_n,
    output logic [1:0] power_state_out
);

    ////////////////////////////////////////////////////////////////////////
    logic [31:0] subsystem_identification_r;
    logic sid_loaded_r;
    logic [7:0] int_line_r;
    logic wake_event_status_r;
    logic wake_event_enable_r;
    pstate_t pstate_r;
    logic wake_sync;
    logic wake_prev_r;
    logic wake_edge;
    logic hit_sid, hit_cap, hit_int, hit_pmcap, hit_pmcsr;
    logic wr_acc, rd_acc;
    logic [31:0] int_word, pmcap_word, pmcsr_word, rd_mux;

    // Event pin is asynchronous
    sync_two_ff u_wake_sync (
        .core_clk_in(core_clk_in),
        .rst_in(pwr_on_rst_in),
        .d_in(wake_event_in),
        .q_out(wake_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    assign hit_sid = cfg_addr_in == OFS_SUBSYS_ID;
    assign hit_cap = cfg_addr_in == OFS_CAP_PTR;
    assign hit_int = cfg_addr_in == OFS_INT_LAT;
    assign hit_pmcap = cfg_addr_in == OFS_PM_CAP;
    assign hit_pmcsr = cfg_addr_in == OFS_PM_CSR;
    assign cfg_hit_out = cfg_req_in &
        (hit_sid | hit_cap | hit_int | hit_pmcap | hit_pmcsr);
    // Subsystem word is not ready until the local load
    assign cfg_retry_out = cfg_req_in & hit_sid & ~sid_loaded_r;
    assign cfg_ack_out = cfg_req_in & ~cfg_retry_out;
    assign wr_acc = cfg_ack_out & cfg_wr_in;
    assign rd_acc = cfg_ack_out & ~cfg_wr_in;

    ////////////////////////////////////////////////////////////////////////
    // Subsystem word, local side only
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            subsystem_identification_r <= SUBSYS_RST;
            sid_loaded_r <= 1'b0;
        end else if (local_sid_wr_in) begin
            subsystem_identification_r <= local_sid_data_in;
            sid_loaded_r <= 1'b1;
        end
    end

    // Routing byte, storage only
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            int_line_r <= INT_LINE_RST;
        end else if (wr_acc && hit_int && cfg_be_in[0]) begin
            int_line_r <= cfg_wdata_in[7:0];
        end
    end

    // Power state; a bus reset returns to uninitialized D0
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pstate_r <= PS_D0;
        end else if (wr_acc && hit_pmcsr && cfg_be_in[0]) begin
            // Leaving D3 hot keeps all context: no internal reset
            pstate_r <= pstate_t'(cfg_wdata_in[1:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wake context lives on the power-up reset only
    always_ff @(posedge core_clk_in or posedge pwr_on_rst_in) begin
        if (pwr_on_rst_in) begin
            wake_prev_r <= 1'b0;
        end else begin
            wake_prev_r <= wake_sync;
        end
    end
    assign wake_edge = wake_sync & ~wake_prev_r;

    always_ff @(posedge core_clk_in or posedge pwr_on_rst_in) begin
        if (pwr_on_rst_in) begin
            wake_event_enable_r <= 1'b0;
        end else if (wr_acc && hit_pmcsr && cfg_be_in[1]) begin
            wake_event_enable_r <= cfg_wdata_in[WAKE_ENABLE_BIT];
        end
    end

    // New event wins over a simultaneous write-one clear
    always_ff @(posedge core_clk_in or posedge pwr_on_rst_in) begin
        if (pwr_on_rst_in) begin
            wake_event_status_r <= 1'b0;
        end else if (wake_edge) begin
            wake_event_status_r <= 1'b1;
        end else if (wr_acc && hit_pmcsr && cfg_be_in[1] &&
                     cfg_wdata_in[WAKE_STATUS_BIT]) begin
            wake_event_status_r <= 1'b0;
        end
    end

    // Combinational so the pin drops with the status bit
    assign wake_event_out_n =
        ~(wake_event_status_r & wake_event_enable_r);
    assign power_state_out = pstate_r;

    ////////////////////////////////////////////////////////////////////////
    // Read-only fields are constants; writes cannot reach them
    assign int_word = {MAX_LAT_RST, MIN_GNT_RST,
                       INT_PIN_VAL, int_line_r};
    assign pmcap_word = {1'b0, 1'b1,
                         3'b000,
                         2'b11,
                         AUX_CUR_VAL,
                         1'b0, 1'b0, 1'b0,
                         PM_VER_VAL,
                         PM_NEXT_VAL,
                         PM_CAP_ID_VAL};
    always_comb begin
        pmcsr_word = 32'h0000_0000;
        pmcsr_word[WAKE_STATUS_BIT] = wake_event_status_r;
        pmcsr_word[WAKE_ENABLE_BIT] = wake_event_enable_r;
        pmcsr_word[NO_SOFT_RST_BIT] = 1'b1;
        pmcsr_word[1:0] = pstate_r;
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_sid) begin
            rd_mux = subsystem_identification_r;
        end
        if (hit_cap) begin
            rd_mux = {24'h00_0000, CAP_PTR_VAL};
        end
        if (hit_int) begin
            rd_mux = int_word;
        end
        if (hit_pmcap) begin
            rd_mux = pmcap_word;
        end
        if (hit_pmcsr) begin
            rd_mux = pmcsr_word;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_rdata_out <= 32'h0000_0000;
        end else if (rd_acc) begin
            cfg_rdata_out <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_retry_unloaded;
        @(posedge core_clk_in) disable iff (rst_in)
        (cfg_req_in && hit_sid && !sid_loaded_r) |->
            (cfg_retry_out && !cfg_ack_out);
    endproperty
    a_retry_unloaded: assert property (p_retry_unloaded)
        else $error("subsystem read before load not retried");

    property p_sid_pci_write;
        @(posedge core_clk_in) disable iff (rst_in)
        (wr_acc && hit_sid && !local_sid_wr_in) |=>
            $stable(subsystem_identification_r);
    endproperty
    a_sid_pci_write: assert property (p_sid_pci_write)
        else $error("subsystem word changed by config write");

    property p_cap_read;
        @(posedge core_clk_in) disable iff (rst_in)
        (rd_acc && hit_cap) |=> cfg_rdata_out == 32'h0000_0050;
    endproperty
    a_cap_read: assert property (p_cap_read)
        else $error("capability pointer wrong");

    property p_int_read;
        @(posedge core_clk_in) disable iff (rst_in)
        (rd_acc && hit_int) |=> cfg_rdata_out[31:8] == 24'h28_1401;
    endproperty
    a_int_read: assert property (p_int_read)
        else $error("latency or pin field wrong");

    property p_pmcap_read;
        @(posedge core_clk_in) disable iff (rst_in)
        (rd_acc && hit_pmcap) |=> cfg_rdata_out == 32'h4603_0001;
    endproperty
    a_pmcap_read: assert property (p_pmcap_read)
        else $error("capability word wrong");

    sequence s_event_seen;
        wake_edge && wake_event_enable_r;
    endsequence
    property p_pin_follows;
        @(posedge core_clk_in) disable iff (pwr_on_rst_in)
        s_event_seen |=> !wake_event_out_n;
    endproperty
    a_pin_follows: assert property (p_pin_follows)
        else $error("wake pin not driven after event");

    property p_status_clear;
        @(posedge core_clk_in) disable iff (pwr_on_rst_in)
        (wr_acc && hit_pmcsr && cfg_be_in[1] &&
         cfg_wdata_in[WAKE_STATUS_BIT] && !wake_edge) |=>
            (!wake_event_status_r && wake_event_out_n);
    endproperty
    a_status_clear: assert property (p_status_clear)
        else $error("write one did not clear event status");

    property p_enable_hold;
        @(posedge core_clk_in) disable iff (pwr_on_rst_in)
        rst_in |=> $stable(wake_event_enable_r);
    endproperty
    a_enable_hold: assert property (p_enable_hold)
        else $error("enable changed by hardware reset");

endmodule : pci_cfg_pm_capability_regs
`default_nettype wire

// File: tb/pci_host_model.sv
/*
 * Behavioural configuration-cycle master for the bench.
 * Assumes callers enter access just after a rising clock edge.
 */
`timescale 1ns/10ps
`default_nettype none
module pci_host_model (
    // Clock
    input wire logic core_clk_in,
    // Request
    output logic req_out,
    output logic wr_out,
    output logic [15:0] addr_out,
    output logic [3:0] be_out,
    output logic [31:0] wdata_out,
    // Answer
    input wire logic ack_in,
    input wire logic retry_in,
    input wire logic [31:0] rdata_in
);
    initial begin
        req_out = 1'b0;
        wr_out = 1'b0;
        addr_out = 16'h0000;
        be_out = 4'h0;
        wdata_out = 32'h0000_0000;
    end

    // Idle cycle first, so two calls never touch req in one step
    task automatic access(input logic wr, input logic [15:0] addr,
            input logic [3:0] be, input logic [31:0] data,
            output logic [31:0] rd, output logic [1:0] resp);
        @(posedge core_clk_in);
        #1;
        req_out = 1'b1;
        wr_out = wr;
        addr_out = addr;
        be_out = be;
        wdata_out = data;
        // Answer taken at the edge that takes the request
        @(posedge core_clk_in);
        resp = {ack_in, retry_in};
        #1;
        rd = rdata_in;
        req_out = 1'b0;
        // Released address and data show no stale value
        addr_out = ~addr;
        wdata_out = ~data;
    endtask : access
endmodule : pci_host_model
`default_nettype wire

// File: tb/testbench.sv
/*
 * Self-checking bench for the configuration and wake-event registers.
 * Assumes the host model in the same folder and the design package.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import pm_cfg_pkg::*;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic pwr_on_rst_in = 1'b1;
    logic cfg_req_in, cfg_wr_in, cfg_ack_out, cfg_retry_out, cfg_hit_out;
    logic [15:0] cfg_addr_in;
    logic [3:0] cfg_be_in;
    logic [31:0] cfg_wdata_in, cfg_rdata_out, d;
    logic local_sid_wr_in = 1'b0;
    logic [31:0] local_sid_data_in = 32'h0000_0000;
    logic wake_event_in = 1'b0;
    logic wake_event_out_n;
    logic [1:0] power_state_out, r;
    logic [31:0] sid_m = 32'h0;
    logic [7:0] line_m = 8'h00;
    logic [1:0] ps_m = 2'h0;
    logic en_m = 1'b0;
    logic st_m = 1'b0;
    logic hit_seen = 1'b0;
    int errors = 0;
    int n_tests = 0;

    pci_cfg_pm_capability_regs pci_cfg_pm_capability_regs_inst (.*);
    pci_host_model pci_host_model_inst (.core_clk_in(core_clk_in),
        .req_out(cfg_req_in), .wr_out(cfg_wr_in), .addr_out(cfg_addr_in),
        .be_out(cfg_be_in), .wdata_out(cfg_wdata_in), .ack_in(cfg_ack_out),
        .retry_in(cfg_retry_out), .rdata_in(cfg_rdata_out));

    always #5 core_clk_in = ~core_clk_in;

    // Decode flag as it stands at the edge that takes the request
    always @(posedge core_clk_in) begin
        if (cfg_req_in) begin
            hit_seen <= cfg_hit_out;
        end
    end

    function automatic logic [31:0] exp_rd(input logic [15:0] a);
        case (a)
            OFS_SUBSYS_ID: return sid_m;
            OFS_CAP_PTR: return {24'h000000, CAP_PTR_VAL};
            OFS_INT_LAT: return {MAX_LAT_RST, MIN_GNT_RST, INT_PIN_VAL,
                line_m};
            OFS_PM_CAP: return {8'h46, 5'h00, PM_VER_VAL, PM_NEXT_VAL,
                PM_CAP_ID_VAL};
            OFS_PM_CSR: return {16'h0000, st_m, 6'h00, en_m, 6'h02, ps_m};
            default: return 32'h0000_0000;
        endcase
    endfunction : exp_rd

    task automatic wrap_up();
        $display("Checks %0d, errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input string nm, input logic [31:0] seen,
            input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic rdchk(input logic [15:0] a);
        logic h;
        h = a inside {OFS_SUBSYS_ID, OFS_CAP_PTR, OFS_INT_LAT, OFS_PM_CAP,
            OFS_PM_CSR};
        pci_host_model_inst.access(1'b0, a, 4'hF, 32'h0, d, r);
        check("read answer", {30'h0, r}, 32'h2);
        check($sformatf("word %h", a), d, exp_rd(a));
        check("hit", {31'h0, hit_seen}, {31'h0, h});
    endtask : rdchk

    task automatic wr(input logic [15:0] a, input logic [3:0] be,
            input logic [31:0] v);
        pci_host_model_inst.access(1'b1, a, be, v, d, r);
        check("write answer", {30'h0, r}, 32'h2);
        if (a == OFS_INT_LAT && be[0]) line_m = v[7:0];
        if (a == OFS_PM_CSR && be[0]) ps_m = v[1:0];
        if (a == OFS_PM_CSR && be[1]) begin
            en_m = v[8];
            if (v[15]) st_m = 1'b0;
        end
    endtask : wr

    task automatic pin();
        logic e;
        e = ~(st_m & en_m);
        check("wake pin", {31'h0, wake_event_out_n}, {31'h0, e});
    endtask : pin

    // Event held through two sync stages, edge detect and status flop;
    // a fixed wait, so a disabled pin cannot cut the pulse short
    task automatic wake();
        wake_event_in = 1'b1;
        st_m = 1'b1;
        repeat (4) begin
            @(posedge core_clk_in);
            #1;
        end
        wake_event_in = 1'b0;
        pin();
        rdchk(OFS_PM_CSR);
    endtask : wake

    task automatic resets(input logic por);
        @(posedge core_clk_in);
        #1;
        rst_in = 1'b1;
        pwr_on_rst_in = por;
        @(posedge core_clk_in);
        #1;
        rst_in = 1'b0;
        pwr_on_rst_in = 1'b0;
        {sid_m, line_m, ps_m} = '0;
        if (por) {st_m, en_m} = 2'b00;
    endtask : resets

    initial begin
        void'($urandom(78));
        repeat (5) @(posedge core_clk_in);
        #1;
        rst_in = 1'b0;
        pwr_on_rst_in = 1'b0;
        pin();
        pci_host_model_inst.access(1'b0, OFS_SUBSYS_ID, 4'hF, 32'h0, d, r);
        check("early id read", {30'h0, r}, 32'h1);
        rdchk(OFS_CAP_PTR);
        rdchk(OFS_INT_LAT);
        rdchk(OFS_PM_CAP);
        rdchk(OFS_PM_CAP);
        rdchk(OFS_PM_CSR);
        for (int k = 0; k < 2; k++) begin
            wr(k ? OFS_PM_CAP : OFS_CAP_PTR, 4'hF, 32'hFFFF_FFFF);
            rdchk(k ? OFS_PM_CAP : OFS_CAP_PTR);
        end
        @(posedge core_clk_in);
        #1;
        local_sid_data_in = $urandom;
        local_sid_wr_in = 1'b1;
        sid_m = local_sid_data_in;
        @(posedge core_clk_in);
        #1;
        local_sid_wr_in = 1'b0;
        rdchk(OFS_SUBSYS_ID);
        wr(OFS_SUBSYS_ID, 4'hF, ~sid_m);
        sid_m = sid_m;
        rdchk(OFS_SUBSYS_ID);
        repeat (8) begin
            wr(OFS_INT_LAT, 4'($urandom), $urandom);
            rdchk(OFS_INT_LAT);
        end
        for (int p = 0; p < 4; p++) begin
            wr(OFS_PM_CSR, 4'h1, 32'(p) | 32'h0000_FFFC);
            rdchk(OFS_PM_CSR);
            check("state out", {30'h0, power_state_out}, 32'(p));
        end
        wake();
        wr(OFS_PM_CSR, 4'h2, 32'h0000_0100);
        pin();
        wr(OFS_PM_CSR, 4'h2, 32'h0000_8100);
        pin();
        wake();
        resets(1'b0);
        pin();
        rdchk(OFS_PM_CSR);
        rdchk(OFS_INT_LAT);
        pci_host_model_inst.access(1'b0, OFS_SUBSYS_ID, 4'hF, 32'h0, d, r);
        check("id after reset", {30'h0, r}, 32'h1);
        resets(1'b1);
        pin();
        rdchk(OFS_PM_CSR);
        rdchk(16'h2040);
        wrap_up();
    end

    initial begin
        #200000;
        errors++;
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
